/* logic/vertical_transfer_sequencer.sv */
// vertical transfer clock sequencer with serial register port
//
// Notes on behaviour
// - each sequence starts at its programmed one-bit start level
// - first and second toggles are 10-bit pixel positions
// - third toggle exists only for sequences zero to seven
// - 10-bit repeat spacing sets pixels between repetitions
// - 12-bit repeat count; one gives one pulse, zero gives dc
// - pool of twelve programmable sequences, zero to eleven
// - per region a 4-bit selector picks the sequence per output
// - selector above eleven holds output at its invert level
// - per-output per-region invert bit flips the sequence polarity
// - five regions, each with its own 12-bit line length
// - each output in each region has a 12-bit start position
// - final line of the field uses its own line length
// - up to eight areas by line boundaries; first fixed at zero
// - each area has a 3-bit selector naming region zero to four
// - alternation set: odd lines use second selectors and inverts
// - alternation clear: all lines use first selectors and inverts
// - start level is the output level held until the first toggle
// - pulse train is cut off at the end of each line
`timescale 1ns/1ns
module vertical_transfer_sequencer
  import vts_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic SER_CLK_I,
  input wire logic SER_DATA_I,
  input wire logic SER_LOAD_I,
  output logic [OUT_COUNT-1:0] VERTICAL_PHASE_O,
  output logic LINE_SYNC_O,
  output logic FIELD_SYNC_O
);

  // configuration storage
  seq_cfg_type seq_cfg_reg [SEQ_COUNT];
  region_cfg_type region_cfg_reg [REGION_COUNT];
  logic [LEN_W-1:0] area_bound_reg [AREA_COUNT];
  logic [RSEL_W-1:0] area_region_reg [AREA_COUNT];
  logic [LEN_W-1:0] final_len_reg;
  logic [LEN_W-1:0] field_lines_reg;

  // serial port synchronisers, two stages each
  logic [1:0] sck_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] sld_sync_reg;
  logic sck_prev_reg;
  logic sld_prev_reg;
  logic [SER_BITS-1:0] shift_reg;
  logic [SER_CNT_W-1:0] bit_cnt_reg;
  logic sck_rise;
  logic frame_commit;
  logic [SER_ADDR_W-1:0] wr_addr;
  logic [SER_DATA_W-1:0] wr_data;
  logic [7:0] region_off;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sck_sync_reg <= 2'h0;
      sda_sync_reg <= 2'h0;
      sld_sync_reg <= 2'h3;
      sck_prev_reg <= 1'b0;
      sld_prev_reg <= 1'b1;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], SER_CLK_I};
      sda_sync_reg <= {sda_sync_reg[0], SER_DATA_I};
      sld_sync_reg <= {sld_sync_reg[0], SER_LOAD_I};
      sck_prev_reg <= sck_sync_reg[1];
      sld_prev_reg <= sld_sync_reg[1];
    end
  end

  assign sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
  // a frame is written when load rises after exactly one frame of bits
  assign frame_commit = sld_sync_reg[1] & ~sld_prev_reg &
                        (bit_cnt_reg == SER_CNT_W'(SER_BITS));
  assign wr_addr = shift_reg[SER_ADDR_W-1:0];
  assign wr_data = shift_reg[SER_BITS-1:SER_ADDR_W];
  assign region_off = wr_addr - REGION_BASE;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
    end else if (sld_sync_reg[1]) begin
      bit_cnt_reg <= '0;
    end else if (sck_rise) begin
      shift_reg <= {sda_sync_reg[1], shift_reg[SER_BITS-1:1]};
      if (bit_cnt_reg != SER_CNT_W'(SER_BITS + 1)) begin
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  // sequence pool registers
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int s = 0; s < SEQ_COUNT; s++) begin
        seq_cfg_reg[s] <= '0;
      end
    end else if (frame_commit && wr_addr <= SEQ_LAST_ADDR) begin
      unique case (wr_addr[2:0])
        SEQ_F_POL: seq_cfg_reg[wr_addr[6:3]].pol <= wr_data[0];
        SEQ_F_TOG1: seq_cfg_reg[wr_addr[6:3]].tog1 <=
          wr_data[POS_W-1:0];
        SEQ_F_TOG2: seq_cfg_reg[wr_addr[6:3]].tog2 <=
          wr_data[POS_W-1:0];
        SEQ_F_TOG3: seq_cfg_reg[wr_addr[6:3]].tog3 <=
          wr_data[POS_W-1:0];
        SEQ_F_SPACING: seq_cfg_reg[wr_addr[6:3]].spacing <=
          wr_data[POS_W-1:0];
        SEQ_F_COUNT: seq_cfg_reg[wr_addr[6:3]].count <= wr_data;
        default: ;
      endcase
    end
  end

  // region registers
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      // selectors reset beyond the pool so every output idles low
      for (int r = 0; r < REGION_COUNT; r++) begin
        region_cfg_reg[r] <= '0;
        for (int v = 0; v < OUT_COUNT; v++) begin
          region_cfg_reg[r].sel_first[v] <= SEL_RESET;
          region_cfg_reg[r].sel_second[v] <= SEL_RESET;
        end
      end
    end else if (frame_commit && wr_addr >= REGION_BASE &&
                 wr_addr <= REGION_LAST_ADDR) begin
      if (region_off[3:0] == REG_F_LEN) begin
        region_cfg_reg[region_off[6:4]].line_len <= wr_data;
      end else if (region_off[3:0] == REG_F_ALT) begin
        region_cfg_reg[region_off[6:4]].alt <= wr_data[0];
      end else if (region_off[3:0] < REG_F_SEL1) begin
        region_cfg_reg[region_off[6:4]].start[region_off[1:0] - 2'h2] <=
          wr_data;
      end else if (region_off[3:0] < REG_F_SEL2) begin
        region_cfg_reg[region_off[6:4]].sel_first[region_off[1:0] - 2'h2] <=
          wr_data[SEL_W-1:0];
      end else if (region_off[3:0] < REG_F_INV1) begin
        region_cfg_reg[region_off[6:4]].sel_second[region_off[1:0] - 2'h2] <=
          wr_data[SEL_W-1:0];
      end else if (region_off[3:0] == REG_F_INV1) begin
        region_cfg_reg[region_off[6:4]].inv_first <=
          wr_data[OUT_COUNT-1:0];
      end else begin
        region_cfg_reg[region_off[6:4]].inv_second <=
          wr_data[OUT_COUNT-1:0];
      end
    end
  end

  // field registers: area boundaries, area regions, final line, field size
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int a = 0; a < AREA_COUNT; a++) begin
        area_bound_reg[a] <= BOUND_RESET;
        area_region_reg[a] <= '0;
      end
      final_len_reg <= LEN_RESET;
      field_lines_reg <= LEN_RESET;
    end else if (frame_commit) begin
      if (wr_addr[7:3] == AREA_BOUND_BASE[7:3] && wr_addr[2:0] != 3'h0) begin
        area_bound_reg[wr_addr[2:0]] <= wr_data;
      end else if (wr_addr[7:3] == AREA_SEL_BASE[7:3]) begin
        area_region_reg[wr_addr[2:0]] <= wr_data[RSEL_W-1:0];
      end else if (wr_addr == FINAL_LEN_ADDR) begin
        final_len_reg <= wr_data;
      end else if (wr_addr == FIELD_LINES_ADDR) begin
        field_lines_reg <= wr_data;
      end
    end
  end

  // line and field timing
  logic [LEN_W-1:0] pix_reg;
  logic [LEN_W-1:0] line_reg;
  logic [AREA_W-1:0] area_idx;
  logic [RSEL_W-1:0] region_idx;
  region_cfg_type cur_region;
  logic last_line;
  logic [LEN_W-1:0] cur_len;
  logic line_end;
  logic use_second;

  always_comb begin
    area_idx = '0;
    for (int a = 1; a < AREA_COUNT; a++) begin
      if (line_reg >= area_bound_reg[a]) begin
        area_idx = AREA_W'(a);
      end
    end
  end

  // a region selector beyond the last region falls back to region zero
  assign region_idx = (area_region_reg[area_idx] < RSEL_W'(REGION_COUNT)) ?
                      area_region_reg[area_idx] : '0;
  assign cur_region = region_cfg_reg[region_idx];
  // a field shortened below the current line closes on that line rather
  // than running the 12-bit line counter all the way round
  assign last_line = (line_reg >= field_lines_reg - 1'b1);
  assign cur_len = last_line ? final_len_reg : cur_region.line_len;
  // a length of zero wraps to a full 4096-pixel line; a line shortened
  // below the current pixel ends at once instead of wrapping the counter
  assign line_end = (pix_reg >= cur_len - 1'b1);
  assign use_second = cur_region.alt & line_reg[0];

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pix_reg <= '0;
      line_reg <= '0;
    end else if (line_end) begin
      pix_reg <= '0;
      line_reg <= last_line ? '0 : line_reg + 1'b1;
    end else begin
      pix_reg <= pix_reg + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LINE_SYNC_O <= 1'b0;
      FIELD_SYNC_O <= 1'b0;
    end else begin
      LINE_SYNC_O <= line_end;
      FIELD_SYNC_O <= line_end & last_line;
    end
  end

  // one pattern engine per vertical output
  for (genvar v = 0; v < OUT_COUNT; v++) begin : g_phase
    logic [SEL_W-1:0] sel;
    logic inv;
    logic sel_valid;
    seq_cfg_type sc;
    logic has_tog3;
    logic hit;
    logic rep_wrap;
    logic run_reg;
    logic level_reg;
    logic [POS_W-1:0] phase_reg;
    logic [LEN_W-1:0] reps_reg;

    assign sel = use_second ? cur_region.sel_second[v] :
                 cur_region.sel_first[v];
    assign inv = use_second ? cur_region.inv_second[v] :
                 cur_region.inv_first[v];
    assign sel_valid = (sel < SEL_W'(SEQ_COUNT));
    // an unused selector feeds an all-zero sequence; the output stage
    // then shows the invert bit alone
    assign sc = sel_valid ? seq_cfg_reg[sel] : '0;
    assign has_tog3 = (sel < SEL_W'(TOG3_SEQS));
    assign hit = (phase_reg == sc.tog1) | (phase_reg == sc.tog2) |
                 (has_tog3 & (phase_reg == sc.tog3));
    // spacing zero means one pattern with no repetition
    assign rep_wrap = (sc.spacing != '0) &&
                      (phase_reg == sc.spacing - 1'b1);

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        run_reg <= 1'b0;
        level_reg <= 1'b0;
        phase_reg <= '0;
        reps_reg <= '0;
      end else if (line_end) begin
        run_reg <= 1'b0;
        level_reg <= sc.pol;
      end else if (pix_reg == cur_region.start[v]) begin
        run_reg <= (sc.count != '0);
        level_reg <= sc.pol;
        phase_reg <= '0;
        reps_reg <= '0;
      end else if (pix_reg == '0) begin
        run_reg <= 1'b0;
        level_reg <= sc.pol;
      end else if (run_reg) begin
        if (rep_wrap) begin
          level_reg <= sc.pol;
          phase_reg <= '0;
          reps_reg <= reps_reg + 1'b1;
          if (reps_reg + 1'b1 >= sc.count) begin
            run_reg <= 1'b0;
          end
        end else begin
          level_reg <= level_reg ^ hit;
          if (phase_reg != '1) begin
            phase_reg <= phase_reg + 1'b1;
          end
        end
      end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        VERTICAL_PHASE_O[v] <= 1'b0;
      end else if (sel_valid) begin
        VERTICAL_PHASE_O[v] <= inv ^ level_reg;
      end else begin
        VERTICAL_PHASE_O[v] <= inv;
      end
    end
  end

endmodule : vertical_transfer_sequencer

/* inc/vts_pkg.sv */
// constants, register map and configuration types of the vertical sequencer
package vts_pkg;
  localparam int SEQ_COUNT = 12;
  localparam int TOG3_SEQS = 8;
  localparam int REGION_COUNT = 5;
  localparam int AREA_COUNT = 8;
  localparam int OUT_COUNT = 4;
  localparam int POS_W = 10;
  localparam int LEN_W = 12;
  localparam int SEL_W = 4;
  localparam int RSEL_W = 3;
  localparam int AREA_W = 3;
  // serial frame: 8 address bits then 12 data bits, lsb first
  localparam int SER_ADDR_W = 8;
  localparam int SER_DATA_W = 12;
  localparam int SER_BITS = SER_ADDR_W + SER_DATA_W;
  localparam int SER_CNT_W = 5;
  // sequence block: address = seq * 8 + field
  localparam logic [7:0] SEQ_LAST_ADDR = 8'h5f;
  localparam logic [2:0] SEQ_F_POL = 3'h0;
  localparam logic [2:0] SEQ_F_TOG1 = 3'h1;
  localparam logic [2:0] SEQ_F_TOG2 = 3'h2;
  localparam logic [2:0] SEQ_F_TOG3 = 3'h3;
  localparam logic [2:0] SEQ_F_SPACING = 3'h4;
  localparam logic [2:0] SEQ_F_COUNT = 3'h5;
  // region block: address = 0x60 + region * 16 + field
  localparam logic [7:0] REGION_BASE = 8'h60;
  localparam logic [7:0] REGION_LAST_ADDR = 8'haf;
  localparam logic [3:0] REG_F_LEN = 4'h0;
  localparam logic [3:0] REG_F_ALT = 4'h1;
  localparam logic [3:0] REG_F_START = 4'h2;
  localparam logic [3:0] REG_F_SEL1 = 4'h6;
  localparam logic [3:0] REG_F_SEL2 = 4'ha;
  localparam logic [3:0] REG_F_INV1 = 4'he;
  localparam logic [3:0] REG_F_INV2 = 4'hf;
  localparam logic [7:0] AREA_BOUND_BASE = 8'hb0;
  localparam logic [7:0] AREA_SEL_BASE = 8'hb8;
  localparam logic [7:0] FINAL_LEN_ADDR = 8'hc0;
  localparam logic [7:0] FIELD_LINES_ADDR = 8'hc1;
  // reset values
  localparam logic [LEN_W-1:0] BOUND_RESET = 12'hfff;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'hf;
  localparam logic [LEN_W-1:0] LEN_RESET = 12'h000;

  typedef struct packed {
    logic pol;
    logic [POS_W-1:0] tog1;
    logic [POS_W-1:0] tog2;
    logic [POS_W-1:0] tog3;
    logic [POS_W-1:0] spacing;
    logic [LEN_W-1:0] count;
  } seq_cfg_type;

  typedef struct packed {
    logic [LEN_W-1:0] line_len;
    logic alt;
    logic [OUT_COUNT-1:0][LEN_W-1:0] start;
    logic [OUT_COUNT-1:0][SEL_W-1:0] sel_first;
    logic [OUT_COUNT-1:0][SEL_W-1:0] sel_second;
    logic [OUT_COUNT-1:0] inv_first;
    logic [OUT_COUNT-1:0] inv_second;
  } region_cfg_type;
endpackage : vts_pkg

/* test/vts_asserts.sv */
// port-level assertions for the vertical sequencer
`timescale 1ns/1ns
module vts_asserts (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic SER_CLK_I,
  input wire logic SER_DATA_I,
  input wire logic SER_LOAD_I,
  input wire logic [3:0] VERTICAL_PHASE_O,
  input wire logic LINE_SYNC_O,
  input wire logic FIELD_SYNC_O
);
  int pix_cnt;
  int line_cnt;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  // cycles since the last line pulse
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) pix_cnt <= 0;
    else pix_cnt <= LINE_SYNC_O ? 1 : pix_cnt + 1;
  end
  // lines since the last field pulse
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) line_cnt <= 0;
    else if (FIELD_SYNC_O) line_cnt <= 0;
    else if (LINE_SYNC_O) line_cnt <= line_cnt + 1;
  end
  sequence quiet_s;
    (VERTICAL_PHASE_O == 4'h0) [*8];
  endsequence
  sequence no_sync_s;
    (!LINE_SYNC_O && !FIELD_SYNC_O) [*8];
  endsequence
  sequence line_pulse_s;
    LINE_SYNC_O ##1 !LINE_SYNC_O;
  endsequence
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    RST_I |-> VERTICAL_PHASE_O == 4'h0 && !LINE_SYNC_O)
    else $error("outputs active during reset");
  AST_IDLE_AFTER_RESET: assert property ($fell(RST_I) |-> quiet_s)
    else $error("phase output moved with reset selectors");
  AST_NO_EARLY_SYNC: assert property ($fell(RST_I) |-> no_sync_s)
    else $error("line pulse right after reset");
  AST_LINE_PULSE: assert property (LINE_SYNC_O |-> line_pulse_s)
    else $error("line pulse longer than one cycle");
  AST_FIELD_PULSE: assert property (
    FIELD_SYNC_O |=> !FIELD_SYNC_O [*8])
    else $error("field pulse repeated");
  AST_FIELD_ON_LINE: assert property (FIELD_SYNC_O |-> LINE_SYNC_O)
    else $error("field pulse without line pulse");
  AST_LINE_BOUND: assert property (pix_cnt <= 4097)
    else $error("line longer than 4096 pixels");
  AST_FIELD_BOUND: assert property (line_cnt <= 4096)
    else $error("field longer than 4096 lines");
endmodule : vts_asserts

bind vertical_transfer_sequencer vts_asserts chk (
  .CORE_CLK_I(CORE_CLK_I),
  .RST_I(RST_I),
  .SER_CLK_I(SER_CLK_I),
  .SER_DATA_I(SER_DATA_I),
  .SER_LOAD_I(SER_LOAD_I),
  .VERTICAL_PHASE_O(VERTICAL_PHASE_O),
  .LINE_SYNC_O(LINE_SYNC_O),
  .FIELD_SYNC_O(FIELD_SYNC_O)
);

/* test/phase_sink.sv */
// vertical driver model: per-line pixel, level and edge tallies
`timescale 1ns/1ns
module phase_sink (
  input wire logic clk_i,
  input wire logic [3:0] phase_i,
  input wire logic line_i,
  input wire logic field_i
);
  int len_q[4];
  int high_q[4][4];
  int rise_q[4][4];
  int hi[4];
  int ri[4];
  int ln = 0;
  int pix = 0;
  logic [3:0] prev = 4'h0;
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      hi[k] = hi[k] + phase_i[k];
      ri[k] = ri[k] + (phase_i[k] & ~prev[k]);
    end
    prev = phase_i;
    pix = pix + 1;
    if (line_i) begin
      len_q[ln] = pix;
      high_q[ln] = hi;
      rise_q[ln] = ri;
      hi = '{default: 0};
      ri = '{default: 0};
      pix = 0;
      ln = field_i ? 0 : (ln + 1) % 4;
    end
  end
endmodule : phase_sink

/* test/testbench.sv */
// self-checking bench: serial setup of sequences, regions and areas
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ser_clk = 1'b0;
  logic ser_data = 1'b0;
  logic ser_load = 1'b1;
  logic [3:0] phase;
  logic line_sync;
  logic field_sync;
  int num_errors = 0;
  int samples_checked = 0;
  int r[10];
  logic [7:0] b;
  // seq, pol, tog3, count, spacing, selector, invert, output, high, rises
  int rows[9][10] = '{
    '{0, 0, 600, 1, 0, 0, 0, 0, 2, 1},
    '{1, 1, 600, 1, 0, 1, 0, 1, 38, 1},
    '{2, 1, 600, 0, 0, 2, 0, 2, 40, 0},
    '{3, 0, 600, 3, 10, 3, 0, 3, 6, 3},
    '{4, 0, 600, 1, 0, 4, 1, 0, 38, 1},
    '{5, 0, 6, 1, 10, 5, 0, 1, 5, 2},
    '{9, 0, 6, 1, 10, 9, 0, 2, 2, 1},
    '{11, 0, 600, 2, 10, 12, 1, 3, 40, 0},
    '{11, 0, 600, 2, 10, 11, 0, 0, 4, 2}};
  always #10 core_clk = ~core_clk;
  vertical_transfer_sequencer dut (
    .CORE_CLK_I(core_clk),
    .RST_I(rst),
    .SER_CLK_I(ser_clk),
    .SER_DATA_I(ser_data),
    .SER_LOAD_I(ser_load),
    .VERTICAL_PHASE_O(phase),
    .LINE_SYNC_O(line_sync),
    .FIELD_SYNC_O(field_sync)
  );
  phase_sink sink (
    .clk_i(core_clk),
    .phase_i(phase),
    .line_i(line_sync),
    .field_i(field_sync)
  );
  task automatic hold(int n);
    repeat (n) @(posedge core_clk);
  endtask : hold
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic check(logic [31:0] got, logic [31:0] exp, string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask : check
  // address bits then data bits, lsb first; n below 20 makes a short frame
  task automatic send(logic [7:0] a, logic [11:0] d, int n = 20);
    logic [19:0] f;
    f = {d, a};
    ser_load <= 1'b0;
    for (int i = 0; i < n; i++) begin
      hold(4);
      ser_clk <= 1'b0;
      ser_data <= f[i];
      hold(4);
      ser_clk <= 1'b1;
    end
    hold(4);
    ser_clk <= 1'b0;
    hold(4);
    ser_load <= 1'b1;
    hold(8);
  endtask : send
  // two field pulses: the second closes a field run wholly on new settings
  task automatic settle();
    int seen;
    int n;
    seen = 0;
    n = 0;
    while (seen < 2) begin
      @(posedge core_clk);
      n++;
      if (field_sync === 1'b1) seen++;
      if (n > 20000) begin
        check(32'h0, 32'h1, "field timeout");
        complete_run();
      end
    end
    hold(2);
  endtask : settle
  initial begin
    hold(2);
    check(32'(phase), 32'h0, "reset level");
    $display("reset test done");
    rst <= 1'b0;
    hold(1);
    send(8'h60, 12'h028);
    send(8'hc0, 12'h014);
    send(8'hc1, 12'h004);
    foreach (rows[i]) begin
      r = rows[i];
      b = 8'(r[0] * 8);
      send(b, 12'(r[1]));
      send(b + 8'h01, 12'h002);
      send(b + 8'h02, 12'h004);
      send(b + 8'h03, 12'(r[2]));
      send(b + 8'h04, 12'(r[4]));
      send(b + 8'h05, 12'(r[3]));
      send(8'(98 + r[7]), 12'h005);
      send(8'(102 + r[7]), 12'(r[5]));
      send(8'h6e, 12'(r[6] << r[7]));
      settle();
      check(sink.high_q[1][r[7]], r[8], "high count");
      check(sink.rise_q[1][r[7]], r[9], "edge count");
      $display("row %0d done", i);
    end
    check(sink.len_q[1], 40, "line length");
    check(sink.len_q[3], 20, "final line");
    send(8'h60, 12'h01e, 19);
    settle();
    check(sink.len_q[1], 40, "short frame");
    $display("short frame test done");
    send(8'h61, 12'h001);
    settle();
    check(sink.rise_q[0][0], 2, "first line");
    check(sink.rise_q[1][0], 0, "second line");
    $display("alternation test done");
    send(8'hb1, 12'h002);
    send(8'hb9, 12'h001);
    send(8'h70, 12'h01e);
    settle();
    check(sink.len_q[0], 40, "area zero");
    check(sink.len_q[2], 30, "area one");
    check(sink.rise_q[2][0], 0, "area one output");
    check(sink.len_q[3], 20, "final line");
    $display("area test done");
    complete_run();
  end
endmodule : testbench
